// *** rtl/asc_cfg.svh ***
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

`define ASC_CLK_PERIOD_NS 10
// Slowest grade figures, so one controller serves every grade
`define ASC_READ_CYCLE_NS 15
`define ASC_ADDR_ACCESS_NS 15
`define ASC_WRITE_CYCLE_NS 15
`define ASC_ADDR_SETUP_END_NS 10
`define ASC_DATA_SETUP_NS 8
`define ASC_LANE_SEL_END_NS 9
`define ASC_SEL_WRITE_END_NS 10
`define ASC_OUT_OFF_NS 7
// Least times round up to whole cycles
`define ASC_CEIL(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_READ_CYC `ASC_CEIL(`ASC_ADDR_ACCESS_NS)
`define ASC_WSTROBE_CYC `ASC_CEIL(`ASC_ADDR_SETUP_END_NS)
`define ASC_TURN_CYC `ASC_CEIL(`ASC_OUT_OFF_NS)
`define ASC_CNT_W 4
`define ASC_ADDR_W 16
`define ASC_DATA_W 16
`define ASC_RESET_DATA 16'h0000

`endif

// *** rtl/asc_pkg.sv ***
`include "asc_cfg.svh"

package asc_pkg;
    typedef struct packed {
        logic write;
        logic [1:0] lane_en;
        logic [`ASC_ADDR_W-1:0] addr;
        logic [`ASC_DATA_W-1:0] wdata;
    } asc_req_t;

    typedef enum logic [2:0] {
        ASC_IDLE,
        ASC_RD,
        ASC_WR,
        ASC_WR_HOLD,
        ASC_TURN
    } asc_state_t;
endpackage

// *** rtl/asc_sram_ctrl.sv ***
`timescale 1ns/1ps
`include "asc_cfg.svh"
module asc_sram_ctrl (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire asc_pkg::asc_req_t req_in,
    output logic req_ready_out,
    output logic [`ASC_DATA_W-1:0] rdata_out,
    output logic rdata_valid_out,
    output logic [`ASC_ADDR_W-1:0] mem_addr_out,
    output logic chip_sel_n_out,
    output logic out_drive_n_out,
    output logic write_n_out,
    output logic low_lane_sel_n_out,
    output logic high_lane_sel_n_out,
    input wire logic [`ASC_DATA_W-1:0] mem_data_in,
    output logic [`ASC_DATA_W-1:0] mem_data_out,
    output logic mem_data_oe_out
);

    asc_pkg::asc_state_t state_ff;
    logic [`ASC_CNT_W-1:0] cnt_ff;
    logic [1:0] lane_ff;
    logic accept;
    logic cnt_done;

    assign accept = req_valid_in && req_ready_out;
    assign cnt_done = (cnt_ff == `ASC_CNT_W'(0));

    ////////////////////////////////////////////////////////////////////
    // Sequencing
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_ff <= asc_pkg::ASC_IDLE;
            cnt_ff <= '0;
        end else begin
            unique case (state_ff)
                asc_pkg::ASC_IDLE: begin
                    if (accept && req_in.write) begin
                        state_ff <= asc_pkg::ASC_WR;
                        cnt_ff <= `ASC_CNT_W'(`ASC_WSTROBE_CYC - 1);
                    end else if (accept) begin
                        state_ff <= asc_pkg::ASC_RD;
                        cnt_ff <= `ASC_CNT_W'(`ASC_READ_CYC);
                    end
                end
                asc_pkg::ASC_RD: begin
                    if (cnt_done) begin
                        state_ff <= asc_pkg::ASC_TURN;
                        cnt_ff <= `ASC_CNT_W'(`ASC_TURN_CYC - 1);
                    end else begin
                        cnt_ff <= cnt_ff - `ASC_CNT_W'(1);
                    end
                end
                asc_pkg::ASC_WR: begin
                    if (cnt_done) begin
                        state_ff <= asc_pkg::ASC_WR_HOLD;
                    end else begin
                        cnt_ff <= cnt_ff - `ASC_CNT_W'(1);
                    end
                end
                asc_pkg::ASC_WR_HOLD: begin
                    state_ff <= asc_pkg::ASC_IDLE;
                end
                asc_pkg::ASC_TURN: begin
                    if (cnt_done) begin
                        state_ff <= asc_pkg::ASC_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - `ASC_CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // Ready only in idle so requests cannot overlap a cycle
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            req_ready_out <= 1'b0;
        end else begin
            req_ready_out <= (state_ff == asc_pkg::ASC_IDLE) && !accept
                || (state_ff == asc_pkg::ASC_WR_HOLD)
                || (state_ff == asc_pkg::ASC_TURN && cnt_done);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address and lanes are latched on accept and held to the end
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mem_addr_out <= '0;
            lane_ff <= 2'h0;
        end else if (accept) begin
            mem_addr_out <= req_in.addr;
            lane_ff <= req_in.lane_en;
        end
    end

    // Strobes; one write takes WSTROBE cycles plus one hold cycle
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            chip_sel_n_out <= 1'b1;
            out_drive_n_out <= 1'b1;
            write_n_out <= 1'b1;
            low_lane_sel_n_out <= 1'b1;
            high_lane_sel_n_out <= 1'b1;
        end else if (accept) begin
            write_n_out <= !req_in.write;
            chip_sel_n_out <= 1'b0;
            out_drive_n_out <= req_in.write;
            low_lane_sel_n_out <= !req_in.lane_en[0];
            high_lane_sel_n_out <= !req_in.lane_en[1];
        end else if ((state_ff == asc_pkg::ASC_WR && cnt_done)
                || (state_ff == asc_pkg::ASC_RD && cnt_done)) begin
            // write ends before address or data change
            write_n_out <= 1'b1;
            chip_sel_n_out <= 1'b1;
            out_drive_n_out <= 1'b1;
            low_lane_sel_n_out <= 1'b1;
            high_lane_sel_n_out <= 1'b1;
        end
    end

    // Data driven for the whole write and one cycle past its end
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mem_data_out <= `ASC_RESET_DATA;
            mem_data_oe_out <= 1'b0;
        end else if (accept && req_in.write) begin
            mem_data_out <= req_in.wdata;
            mem_data_oe_out <= 1'b1;
        end else if (state_ff == asc_pkg::ASC_WR_HOLD) begin
            mem_data_oe_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Capture after access time; unselected lanes read as zero
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rdata_out <= `ASC_RESET_DATA;
            rdata_valid_out <= 1'b0;
        end else begin
            rdata_valid_out <= (state_ff == asc_pkg::ASC_RD) && cnt_done;
            if ((state_ff == asc_pkg::ASC_RD) && cnt_done) begin
                rdata_out <= mem_data_in & {{8{lane_ff[1]}}, {8{lane_ff[0]}}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // no strobe on read
    a_read_no_strobe: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !out_drive_n_out |-> write_n_out)
        else $error("write strobe low while outputs enabled");

    sequence s_write_start;
        $fell(write_n_out);
    endsequence

    sequence s_write_end;
        write_n_out && $stable(mem_addr_out);
    endsequence

    sequence s_read_open;
        !out_drive_n_out [*3];
    endsequence

    a_write_width: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        s_write_start |=> s_write_end)
        else $error("write strobe width wrong");

    a_addr_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !write_n_out |=> $stable(mem_addr_out))
        else $error("address moved during write");

    a_data_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        $rose(write_n_out) |-> mem_data_oe_out)
        else $error("write data released before write end");

    a_data_setup: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !write_n_out |-> mem_data_oe_out)
        else $error("strobe low without write data");

    a_read_length: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        $fell(out_drive_n_out) |-> s_read_open ##1 rdata_valid_out)
        else $error("read data captured at wrong time");

    a_addr_at_sel: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !chip_sel_n_out |=> $stable(mem_addr_out) || $rose(chip_sel_n_out)
            || $fell(chip_sel_n_out))
        else $error("address changed while selected");

    a_write_space: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        $rose(write_n_out) |-> write_n_out [*2])
        else $error("writes too close together");

    a_lane_in_write: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !write_n_out |-> !chip_sel_n_out && (low_lane_sel_n_out == !lane_ff[0])
            && (high_lane_sel_n_out == !lane_ff[1]))
        else $error("lane select wrong during write");

endmodule

// *** tb/asc_sram_model.sv ***
`timescale 1ns/1ps
module asc_sram_model #(
    parameter int ACC_NS = 15
) (
    input wire logic mclk_in,
    input wire logic [15:0] addr_in,
    input wire logic chip_sel_n_in,
    input wire logic out_drive_n_in,
    input wire logic write_n_in,
    input wire logic low_lane_sel_n_in,
    input wire logic high_lane_sel_n_in,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out
);
    logic [15:0] mem_ff [0:65535];
    logic [15:0] float_ff = 16'h5A5A;
    logic [15:0] rd_val;
    logic [1:0] lane_on;
    ////////////////////////////////////////////////////////////////////////
    // old word stays until access time runs out
    assign #(ACC_NS) rd_val = mem_ff[addr_in];
    // lanes drive only in a selected read
    assign lane_on = {!high_lane_sel_n_in, !low_lane_sel_n_in} &
        {2{!chip_sel_n_in && !out_drive_n_in && write_n_in}};
    // Released lanes wander so a stale value never passes
    assign data_out[7:0] = lane_on[0] ? rd_val[7:0] : float_ff[7:0];
    assign data_out[15:8] = lane_on[1] ? rd_val[15:8] : float_ff[15:8];
    always @(posedge mclk_in) begin
        float_ff <= float_ff + 16'h3C7;
    end
    ////////////////////////////////////////////////////////////////////////
    // store selected lanes only
    always @(posedge mclk_in) begin
        if (!chip_sel_n_in && !write_n_in) begin
            if (!low_lane_sel_n_in) mem_ff[addr_in][7:0] <= data_in[7:0];
            if (!high_lane_sel_n_in) mem_ff[addr_in][15:8] <= data_in[15:8];
        end
    end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic clk;
    logic rst;
    logic req_valid;
    asc_pkg::asc_req_t req;
    logic req_ready, rdata_valid, cs_n, oe_n, we_n, lo_n, hi_n, drv, we_q;
    logic [15:0] rdata, mem_addr, wr_data, sram_q, bus, addr_q, data_q;
    logic [15:0] w_addr, w_data;
    logic [15:0] ref_mem [8];
    logic [15:0] addrs [8];
    logic [31:0] r;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    assign bus = drv ? wr_data : sram_q;
    asc_sram_ctrl u_dut (.mclk_in(clk), .sys_rst_in(rst), .req_valid_in(req_valid),
        .req_in(req), .req_ready_out(req_ready), .rdata_out(rdata),
        .rdata_valid_out(rdata_valid), .mem_addr_out(mem_addr), .chip_sel_n_out(cs_n),
        .out_drive_n_out(oe_n), .write_n_out(we_n), .low_lane_sel_n_out(lo_n),
        .high_lane_sel_n_out(hi_n), .mem_data_in(bus), .mem_data_out(wr_data),
        .mem_data_oe_out(drv));
    asc_sram_model #(.ACC_NS(15)) u_sram (.mclk_in(clk), .addr_in(mem_addr),
        .chip_sel_n_in(cs_n), .out_drive_n_in(oe_n), .write_n_in(we_n),
        .low_lane_sel_n_in(lo_n), .high_lane_sel_n_in(hi_n), .data_in(bus),
        .data_out(sram_q));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] expect_rd(input int idx, input logic [1:0] ln);
        return {ln[1] ? ref_mem[idx][15:8] : 8'h00, ln[0] ? ref_mem[idx][7:0] : 8'h00};
    endfunction
    task automatic access(input logic w, input logic [1:0] ln, input int idx,
        input logic [15:0] d);
        int n;
        n = 0;
        // Let an edge pass so valid never drops and rises in one step
        @(posedge clk);
        #1;
        req = '{write: w, lane_en: ln, addr: addrs[idx], wdata: d};
        req_valid = 1'b1;
        if (w) begin
            w_addr = addrs[idx];
            w_data = d;
        end
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        #1 req_valid = 1'b0;
        if (w) begin
            if (ln[0]) ref_mem[idx][7:0] = d[7:0];
            if (ln[1]) ref_mem[idx][15:8] = d[15:8];
        end else begin
            repeat (3) @(posedge clk);
            #1;
            check({15'h0, rdata_valid}, 16'h0001);
            check(rdata, expect_rd(idx, ln));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Bus watcher; also cuts a hang short
    always @(posedge clk) begin
        if (!rst) begin
            cycles <= cycles + 1;
            if (cs_n === 1'b0 && oe_n === 1'b0) check({15'h0, we_n}, 16'h0001);
            if (drv === 1'b1) check({15'h0, oe_n}, 16'h0001);
            if (we_n === 1'b0) check(mem_addr, w_addr);
            if (we_n === 1'b0) check(wr_data, w_data);
            if (we_n === 1'b1 && we_q === 1'b0) check(mem_addr, addr_q);
            if (we_n === 1'b1 && we_q === 1'b0) check(wr_data, data_q);
            if (we_n === 1'b1 && we_q === 1'b0) check({15'h0, drv}, 16'h0001);
            if (cycles >= 20000) begin
                bad_count++;
                conclude();
            end
        end
        we_q <= we_n;
        addr_q <= mem_addr;
        data_q <= wr_data;
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        void'($urandom(32'h5030));
        addrs[0] = 16'h0000;
        addrs[7] = 16'hFFFF;
        for (int i = 1; i < 7; i++) addrs[i] = {13'($urandom), 3'(i)};
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 8; i++) access(1'b1, 2'b11, i, 16'($urandom));
        // Every lane code, read back from the last word written
        for (int l = 0; l < 4; l++) access(1'b0, 2'(l), 7, 16'h0000);
        access(1'b1, 2'b01, 0, 16'hA5C3);
        access(1'b0, 2'b11, 0, 16'h0000);
        access(1'b1, 2'b10, 7, 16'h3CA5);
        access(1'b1, 2'b00, 7, 16'hFFFF);
        access(1'b0, 2'b11, 7, 16'h0000);
        repeat (300) begin
            r = $urandom;
            access(r[0], r[2:1], int'(r[5:3]), r[31:16]);
        end
        conclude();
    end
endmodule
